/* esiu_top.sv */
// Extended stack instruction unit: indexed moves, push literal, pointer subtract
// with optional return, and remapping of standard file operands.
// Assumes the fetch stage offers words with valid/ready and data memory presents
// read data during the cycle in which the read strobe stands.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none

module esiu_top
  import esiu_pkg::*;
#(
  parameter logic [ADDR_W-1:0] INDIR_LO = INDIR_LO_DEF,
  parameter logic [ADDR_W-1:0] INDIR_HI = INDIR_HI_DEF
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // APB slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic                    o_pready,
  output logic [31:0]             o_prdata,
  output logic                    o_pslverr,
  // Instruction words
  input  wire logic               i_instr_valid,
  input  wire logic [INSTR_W-1:0] i_instr,
  output logic                    o_instr_ready,
  // Return path
  input  wire logic [PC_W-1:0]    i_return_top,
  output logic                    o_pc_load,
  output logic [PC_W-1:0]         o_pc_value,
  // Data memory
  output logic                    o_mem_rd,
  output logic                    o_mem_wr,
  output logic [ADDR_W-1:0]       o_mem_addr,
  output logic [DATA_W-1:0]       o_mem_wdata,
  input  wire logic [DATA_W-1:0]  i_mem_rdata,
  // Standard file operand remapping
  input  wire logic               i_file_valid,
  input  wire logic [7:0]         i_file_operand,
  input  wire logic               i_file_access,
  input  wire logic               i_file_dest,
  input  wire logic [3:0]         i_bank_select,
  output logic                    o_file_valid,
  output logic [ADDR_W-1:0]       o_file_addr,
  output logic                    o_file_dest
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (INDIR_LO > INDIR_HI) begin : g_bad_range
    $error("esiu_top: indirect register range is reversed");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  esiu_state_t       state;
  esiu_state_t       next_state;
  logic              ext_en;
  logic [ADDR_W-1:0] ptr [3];
  logic [ADDR_W-1:0] src_addr;
  logic              src_indir;
  logic              move_kind;
  logic [ADDR_W-1:0] dst_addr;

  // ****************************************************************
  // Decode of the offered word
  // ****************************************************************
  logic              take;
  logic [7:0]        op_hi;
  logic [1:0]        sel;
  logic [5:0]        lit6;
  logic [ADDR_W-1:0] idx_addr;
  logic [ADDR_W-1:0] word2_dst;
  logic              word2_ok;
  logic              dst_indir;

  assign take = i_instr_valid && o_instr_ready;
  assign op_hi = i_instr[15:8];
  assign sel = i_instr[7:6];
  assign lit6 = i_instr[5:0];
  // Stack pointer plus the low 7 bits, wrapping in 12 bits
  assign idx_addr = ADDR_W'(ptr[SEL_STACK] + {5'h00, i_instr[6:0]});
  assign word2_ok = (i_instr[15:12] == OP_WORD2);
  assign word2_dst = move_kind ? idx_addr : i_instr[11:0];
  assign dst_indir = (word2_dst >= INDIR_LO) && (word2_dst <= INDIR_HI);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take && ext_en) begin
          if (op_hi == OP_MOVE) begin
            next_state = ST_WORD2;
          end else if (op_hi == OP_SUB && sel == SEL_RETURN) begin
            next_state = ST_NOP;
          end
        end
      end
      ST_WORD2: begin
        if (take) begin
          // A bad second word or an indirect indexed destination ends as a no-op
          if (word2_ok && !(move_kind && dst_indir)) begin
            next_state = ST_READ;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_READ: next_state = ST_IDLE;
      ST_NOP:  next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      o_instr_ready <= 1'b0;
    end else begin
      state <= next_state;
      o_instr_ready <= (next_state == ST_IDLE) || (next_state == ST_WORD2);
    end
  end

  // ****************************************************************
  // Move operands
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      src_addr <= '0;
      src_indir <= 1'b0;
      move_kind <= 1'b0;
      dst_addr <= '0;
    end else if (take && state == ST_IDLE) begin
      src_addr <= idx_addr;
      src_indir <= (idx_addr >= INDIR_LO) && (idx_addr <= INDIR_HI);
      move_kind <= i_instr[MOVE_KIND_BIT];
    end else if (take && state == ST_WORD2) begin
      dst_addr <= word2_dst;
    end
  end

  // ****************************************************************
  // Data memory strobes
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_addr <= '0;
      o_mem_wdata <= '0;
    end else begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      if (state == ST_IDLE && take && ext_en && op_hi == OP_PUSH) begin
        o_mem_wr <= 1'b1;
        o_mem_addr <= ptr[SEL_STACK];
        o_mem_wdata <= i_instr[7:0];
      end else if (state == ST_WORD2 && take && next_state == ST_READ) begin
        // An indirect source is never read: no side effects on its pointer
        o_mem_rd <= !src_indir;
        o_mem_addr <= src_addr;
      end else if (state == ST_READ) begin
        o_mem_wr <= 1'b1;
        o_mem_addr <= dst_addr;
        o_mem_wdata <= src_indir ? INDIR_READ_VALUE : i_mem_rdata;
      end
    end
  end

  // ****************************************************************
  // Return request
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pc_load <= 1'b0;
      o_pc_value <= '0;
    end else begin
      o_pc_load <= 1'b0;
      if (state == ST_IDLE && next_state == ST_NOP) begin
        o_pc_load <= 1'b1;
        o_pc_value <= i_return_top;
      end
    end
  end

  // ****************************************************************
  // Pointers and control (APB writes lose to instruction updates)
  // ****************************************************************
  logic apb_wr;
  logic apb_setup;
  assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;
  assign apb_setup = i_psel && !i_penable;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_en <= CTRL_EXT_RST;
    end else if (apb_wr && i_paddr == REG_CTRL) begin
      ext_en <= i_pwdata[CTRL_EXT_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr[0] <= PTR_RST;
      ptr[1] <= PTR_RST;
      ptr[2] <= PTR_RST;
    end else if (state == ST_IDLE && take && ext_en && op_hi == OP_PUSH) begin
      ptr[SEL_STACK] <= ADDR_W'(ptr[SEL_STACK] - 12'h001);
    end else if (state == ST_IDLE && take && ext_en && op_hi == OP_SUB) begin
      if (sel == SEL_RETURN) begin
        ptr[SEL_STACK] <= ADDR_W'(ptr[SEL_STACK] - {6'h00, lit6});
      end else begin
        ptr[sel] <= ADDR_W'(ptr[sel] - {6'h00, lit6});
      end
    end else if (apb_wr) begin
      if (i_paddr == REG_PTR0) begin
        ptr[0] <= i_pwdata[ADDR_W-1:0];
      end else if (i_paddr == REG_PTR1) begin
        ptr[1] <= i_pwdata[ADDR_W-1:0];
      end else if (i_paddr == REG_PTR2) begin
        ptr[2] <= i_pwdata[ADDR_W-1:0];
      end
    end
  end

  // ****************************************************************
  // APB answer: ready and data prepared in the setup cycle
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_setup;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
      if (apb_setup) begin
        if (i_paddr == REG_CTRL) begin
          o_prdata <= {31'h0, ext_en};
        end else if (i_paddr == REG_PTR0) begin
          o_prdata <= {20'h0, ptr[0]};
        end else if (i_paddr == REG_PTR1) begin
          o_prdata <= {20'h0, ptr[1]};
        end else if (i_paddr == REG_PTR2) begin
          o_prdata <= {20'h0, ptr[2]};
        end else if (i_paddr == REG_STATUS) begin
          o_prdata <= {28'h0, state};
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Standard operand remapping
  // ****************************************************************
  esiu_map_if map_bus ();
  assign map_bus.operand = i_file_operand;
  assign map_bus.access_bit = i_file_access;
  assign map_bus.ext_en = ext_en;
  assign map_bus.stack_ptr = ptr[SEL_STACK];
  assign map_bus.bank = i_bank_select;

  esiu_addr_map u_map (
    .m (map_bus.mapper)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_file_valid <= 1'b0;
      o_file_addr <= '0;
      o_file_dest <= 1'b0;
    end else begin
      o_file_valid <= i_file_valid;
      o_file_addr <= map_bus.addr;
      o_file_dest <= i_file_dest;
    end
  end

endmodule
`default_nettype wire

/* esiu_pkg.sv */
// Shared constants for the extended stack instruction unit.
// Assumes a 12-bit data address space and 16-bit instruction words.
package esiu_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned PC_W = 21;

  // ****************************************************************
  // Opcode fields
  // ****************************************************************
  localparam logic [7:0] OP_SUB = 8'he9;
  localparam logic [7:0] OP_PUSH = 8'hea;
  localparam logic [7:0] OP_MOVE = 8'heb;
  localparam logic [3:0] OP_WORD2 = 4'hf;
  localparam int unsigned MOVE_KIND_BIT = 7;
  localparam logic [1:0] SEL_RETURN = 2'h3;
  localparam logic [1:0] SEL_STACK = 2'h2;

  // ****************************************************************
  // Address mapping
  // ****************************************************************
  localparam logic [7:0] OFFSET_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [ADDR_W-1:0] INDIR_LO_DEF = 12'hfd9;
  localparam logic [ADDR_W-1:0] INDIR_HI_DEF = 12'hfef;

  // ****************************************************************
  // Register map (byte addresses) and reset values
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PTR0 = 8'h04;
  localparam logic [7:0] REG_PTR1 = 8'h08;
  localparam logic [7:0] REG_PTR2 = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int unsigned CTRL_EXT_BIT = 0;
  localparam logic CTRL_EXT_RST = 1'b0;
  localparam logic [ADDR_W-1:0] PTR_RST = 12'h000;
  localparam logic [DATA_W-1:0] INDIR_READ_VALUE = 8'h00;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WORD2 = 4'b0010,
    ST_READ  = 4'b0100,
    ST_NOP   = 4'b1000
  } esiu_state_t;

endpackage

/* esiu_map_if.sv */
// Carries a file operand to the address mapper and the mapped address back.
// Assumes a purely combinational mapper.
`timescale 1ns/1ns
`default_nettype none
interface esiu_map_if;
  import esiu_pkg::*;
  logic [7:0]        operand;
  logic              access_bit;
  logic              ext_en;
  logic [ADDR_W-1:0] stack_ptr;
  logic [3:0]        bank;
  logic [ADDR_W-1:0] addr;
  modport requester (output operand, access_bit, ext_en, stack_ptr, bank, input addr);
  modport mapper (input operand, access_bit, ext_en, stack_ptr, bank, output addr);
endinterface
`default_nettype wire

/* esiu_addr_map.sv */
// Maps the 8-bit file operand of standard byte and bit instructions to a data address.
// Assumes the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module esiu_addr_map
  import esiu_pkg::*;
(
  esiu_map_if.mapper m
);
  always_comb begin
    if (m.access_bit) begin
      m.addr = {m.bank, m.operand};
    end else if (m.ext_en && (m.operand <= OFFSET_LIMIT)) begin
      // Zero pointer gives the plain low access bank again
      m.addr = ADDR_W'(m.stack_ptr + {4'h0, m.operand});
    end else if (m.operand <= OFFSET_LIMIT) begin
      m.addr = {ACCESS_LO_BANK, m.operand};
    end else begin
      m.addr = {ACCESS_HI_BANK, m.operand};
    end
  end
endmodule
`default_nettype wire

/* esiu_top_monitor.sv */
// Assertion checker for esiu_top, bound to its ports.
// Assumes the control register changes only through the APB port.
`timescale 1ns/1ns
`default_nettype none
module esiu_top_monitor
  import esiu_pkg::*;
(
  // Clock, reset and APB
  input wire logic               i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr,
  input wire logic [7:0]         i_paddr,
  input wire logic [31:0]        i_pwdata, o_prdata,
  // Instructions, return path, data memory and mapped file address
  input wire logic               i_instr_valid, o_instr_ready, o_pc_load, o_mem_rd, o_mem_wr,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic [PC_W-1:0]    i_return_top, o_pc_value,
  input wire logic [ADDR_W-1:0]  o_mem_addr, o_file_addr,
  input wire logic [DATA_W-1:0]  o_mem_wdata, i_mem_rdata,
  // File operand remapping
  input wire logic               i_file_valid, i_file_access, i_file_dest, o_file_valid, o_file_dest,
  input wire logic [7:0]         i_file_operand,
  input wire logic [3:0]         i_bank_select
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // Mirror of the enable bit, which the design keeps internal
  logic ext_q;
  logic taken;
  assign taken = i_instr_valid && o_instr_ready && ext_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_q <= CTRL_EXT_RST;
    end else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == REG_CTRL) begin
      ext_q <= i_pwdata[CTRL_EXT_BIT];
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence abs_read_s;
    taken && i_instr[15:7] == {OP_MOVE, 1'h0} ##1 taken && i_instr[15:12] == OP_WORD2 ##1 o_mem_rd;
  endsequence
  sequence ret_taken_s;
    taken && i_instr[15:6] == {OP_SUB, SEL_RETURN};
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_APB_WAIT_FREE: assert property (i_psel && !i_penable |=> o_pready)
    else $error("APB access cycle without ready");
  AST_APB_UNMAPPED: assert property (o_pready && i_paddr > REG_STATUS |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_PUSH_WRITE: assert property (taken && i_instr[15:8] == OP_PUSH |=> o_mem_wr && o_mem_wdata == $past(i_instr[7:0]))
    else $error("push literal not written");
  AST_SUB_ONE_CYCLE: assert property (taken && i_instr[15:8] == OP_SUB && i_instr[7:6] != SEL_RETURN |=> o_instr_ready && !o_pc_load && !o_mem_wr)
    else $error("pointer subtract not single cycle");
  AST_SUB_RETURN: assert property (ret_taken_s |=> o_pc_load && !o_instr_ready && o_pc_value == $past(i_return_top) ##1 !o_pc_load && o_instr_ready)
    else $error("return after subtract wrong");
  AST_MOVE_ABS: assert property (abs_read_s |=> o_mem_wr && o_mem_addr == $past(i_instr[11:0], 2) ##1 o_instr_ready)
    else $error("absolute move destination wrong");
  AST_READ_THEN_WRITE: assert property (o_mem_rd |-> !o_instr_ready ##1 o_mem_wr)
    else $error("move read not followed by write");
  AST_IGNORED_DISABLED: assert property (i_instr_valid && o_instr_ready && !ext_q |=> !o_mem_wr && !o_mem_rd && !o_pc_load)
    else $error("instruction acted while disabled");
  AST_FILE_BANKED: assert property (i_file_valid && i_file_access |=> o_file_valid && o_file_addr == {$past(i_bank_select), $past(i_file_operand)})
    else $error("banked file address wrong");
  AST_FILE_LEGACY: assert property (i_file_valid && !i_file_access && (!ext_q || i_file_operand > OFFSET_LIMIT) |=> o_file_addr == {($past(i_file_operand) > OFFSET_LIMIT) ? ACCESS_HI_BANK : ACCESS_LO_BANK, $past(i_file_operand)})
    else $error("access bank file address wrong");
  AST_FILE_DEST: assert property (i_file_valid |=> o_file_dest == $past(i_file_dest))
    else $error("file destination bit changed");
endmodule

bind esiu_top esiu_top_monitor u_esiu_top_monitor (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .i_instr_valid(i_instr_valid), .o_instr_ready(o_instr_ready),
  .o_pc_load(o_pc_load), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .i_instr(i_instr),
  .i_return_top(i_return_top), .o_pc_value(o_pc_value), .o_mem_addr(o_mem_addr),
  .o_file_addr(o_file_addr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
  .i_file_valid(i_file_valid), .i_file_access(i_file_access), .i_file_dest(i_file_dest),
  .o_file_valid(o_file_valid), .o_file_dest(o_file_dest), .i_file_operand(i_file_operand),
  .i_bank_select(i_bank_select)
);
`default_nettype wire

/* esiu_tb_top.sv */
// Self-checking testbench for esiu_top: a table of file operand cases,
// then hand-written instruction, register and reset cases.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module esiu_tb_top;
  import esiu_pkg::*;
  typedef struct packed {logic ext; logic acc; logic [7:0] f; logic [3:0] bank;
                         logic dest; logic [11:0] ptr; logic [11:0] exp;} esiu_row_t;
  logic i_clk = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
  logic i_instr_valid = 1'h0, i_file_valid = 1'h0, i_file_access = 1'h0, i_file_dest = 1'h0;
  logic [7:0] i_paddr = 8'h0, i_file_operand = 8'h0, i_mem_rdata = 8'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rdat;
  logic [15:0] i_instr = 16'h0;
  logic [20:0] i_return_top = 21'h0, o_pc_value, pc_val;
  logic [3:0] i_bank_select = 4'h0;
  logic o_pready, o_pslverr, o_instr_ready, o_pc_load, o_mem_rd, o_mem_wr, o_file_valid, o_file_dest;
  logic [11:0] o_mem_addr, o_file_addr, wr_addr, rd_addr;
  logic [7:0] o_mem_wdata, wr_data;
  int err_count = 0, checks_done = 0, cyc = 0, wr_cnt = 0, rd_cnt = 0, pc_cnt = 0;
  // Operand at 5Fh and 60h brackets the offset limit; FFAh pointer wraps
  esiu_row_t rows [10] = '{
    '{1'h0, 1'h0, 8'h20, 4'h3, 1'h1, 12'h000, 12'h020}, '{1'h0, 1'h0, 8'h60, 4'h3, 1'h0, 12'h000, 12'hf60},
    '{1'h0, 1'h1, 8'h20, 4'h3, 1'h1, 12'h000, 12'h320}, '{1'h1, 1'h0, 8'h20, 4'h3, 1'h0, 12'ha00, 12'ha20},
    '{1'h1, 1'h0, 8'h5f, 4'h3, 1'h1, 12'ha00, 12'ha5f}, '{1'h1, 1'h0, 8'h60, 4'h3, 1'h0, 12'ha00, 12'hf60},
    '{1'h1, 1'h1, 8'h20, 4'h5, 1'h1, 12'ha00, 12'h520}, '{1'h1, 1'h0, 8'h10, 4'h0, 1'h0, 12'hffa, 12'h00a},
    '{1'h1, 1'h0, 8'h20, 4'h0, 1'h1, 12'h000, 12'h020}, '{1'h1, 1'h0, 8'h70, 4'h0, 1'h0, 12'h000, 12'hf70}};

  esiu_top u_esiu_top (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .o_instr_ready(o_instr_ready), .i_return_top(i_return_top), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .i_file_valid(i_file_valid),
    .i_file_operand(i_file_operand), .i_file_access(i_file_access), .i_file_dest(i_file_dest),
    .i_bank_select(i_bank_select), .o_file_valid(o_file_valid), .o_file_addr(o_file_addr),
    .o_file_dest(o_file_dest));

  always #25 i_clk = ~i_clk;
  // ****************************************************************
  // Data memory stand-in, strobe log and timeout
  // ****************************************************************
  always @(posedge i_clk) begin
    cyc++;
    if (o_mem_rd === 1'h1) begin
      rd_cnt++;
      rd_addr = o_mem_addr;
    end
    if (o_mem_wr === 1'h1) begin
      wr_cnt++;
      wr_addr = o_mem_addr;
      wr_data = o_mem_wdata;
    end
    if (o_pc_load === 1'h1) begin
      pc_cnt++;
      pc_val = o_pc_value;
    end
    if (cyc == 5000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", s, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    do @(posedge i_clk); while (o_pready !== 1'h1);
    rdat = (o_pslverr === 1'h1) ? ~o_prdata : o_prdata;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'h0, a, 32'h0);
    chk(s, rdat, e);
  endtask
  task automatic exec(input logic [15:0] w1, input logic [15:0] w2, input logic two);
    i_instr_valid <= 1'h1;
    i_instr <= w1;
    do @(posedge i_clk); while (o_instr_ready !== 1'h1);
    if (two) begin
      i_instr <= w2;
      do @(posedge i_clk); while (o_instr_ready !== 1'h1);
    end
    i_instr_valid <= 1'h0;
    repeat (5) @(posedge i_clk);
  endtask
  task automatic mv(input logic [11:0] p, input logic [15:0] w1, input logic [15:0] w2,
                    input int nrd, input int nwr, input logic [11:0] a, input logic [7:0] d,
                    input logic [11:0] s);
    int r0;
    int w0;
    wr(REG_PTR2, {20'h0, p});
    // Read data is taken in the strobe cycle, so the source word stands ahead of it
    i_mem_rdata <= s[7:0] ^ 8'ha5;
    r0 = rd_cnt;
    w0 = wr_cnt;
    exec(w1, w2, 1'h1);
    chk("reads", rd_cnt - r0, nrd);
    chk("writes", wr_cnt - w0, nwr);
    if (nrd > 0) begin
      chk("read address", {20'h0, rd_addr}, {20'h0, s});
    end
    if (nwr > 0) begin
      chk("write address", {20'h0, wr_addr}, {20'h0, a});
      chk("write data", {24'h0, wr_data}, {24'h0, d});
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'h0;
    repeat (2) @(posedge i_clk);
    foreach (rows[n]) begin
      wr(REG_CTRL, {31'h0, rows[n].ext});
      wr(REG_PTR2, {20'h0, rows[n].ptr});
      i_file_valid <= 1'h1;
      i_file_access <= rows[n].acc;
      i_file_operand <= rows[n].f;
      i_bank_select <= rows[n].bank;
      i_file_dest <= rows[n].dest;
      repeat (2) @(posedge i_clk);
      i_file_valid <= 1'h0;
      chk("file address", {20'h0, o_file_addr}, {20'h0, rows[n].exp});
      chk("file dest", {30'h0, o_file_valid, o_file_dest}, {30'h0, 1'h1, rows[n].dest});
    end
    wr(REG_CTRL, 32'h0);
    mv(12'h080, 16'hea08, 16'heb05, 0, 0, 12'h0, 8'h0, 12'h000);
    rd(REG_PTR2, 32'h080, "stack pointer");
    wr(REG_CTRL, 32'h1);
    mv(12'h001, 16'hea08, 16'hea5c, 0, 2, 12'h000, 8'h5c, 12'h000);
    rd(REG_PTR2, 32'hfff, "stack pointer");
    for (int s = 0; s < 3; s++) begin
      wr(REG_PTR0 + 8'(4 * s), 32'h3ff);
      exec({OP_SUB, 2'(s), 6'h23}, 16'h0, 1'h0);
      rd(REG_PTR0 + 8'(4 * s), 32'h3dc, "pointer");
    end
    wr(REG_PTR1, 32'h010);
    exec({OP_SUB, 2'h1, 6'h3f}, 16'h0, 1'h0);
    rd(REG_PTR1, 32'hfd1, "pointer");
    i_return_top <= 21'h1abcd;
    wr(REG_PTR2, 32'h3ff);
    exec({OP_SUB, SEL_RETURN, 6'h23}, 16'h0, 1'h0);
    chk("return count", pc_cnt, 1);
    chk("return value", {11'h0, pc_val}, 32'h1abcd);
    rd(REG_PTR2, 32'h3dc, "stack pointer");
    // Move destinations stay clear of program counter low and return top bytes
    mv(12'h080, 16'heb05, 16'hf123, 1, 1, 12'h123, 8'h20, 12'h085);
    mv(12'hf80, 16'heb7f, 16'hf000, 1, 1, 12'h000, 8'h5a, 12'hfff);
    mv(12'h080, 16'heb85, 16'hf006, 1, 1, 12'h086, 8'h20, 12'h085);
    mv(12'hffa, 16'heb90, 16'hf011, 1, 1, 12'h00b, 8'haf, 12'h00a);
    mv(12'hfd0, 16'heb10, 16'hf123, 0, 1, 12'h123, 8'h00, 12'hfe0);
    mv(12'hfd0, 16'heb80, 16'hf010, 0, 0, 12'h000, 8'h00, 12'hfd0);
    mv(12'h080, 16'heb05, 16'h0123, 0, 0, 12'h000, 8'h00, 12'h085);
    rd(8'h14, 32'hffffffff, "unmapped read");
    // Second reset in mid-run must clear the enable and the stack pointer
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'h0;
    rd(REG_CTRL, 32'h0, "control");
    rd(REG_PTR2, 32'h0, "stack pointer");
    rd(REG_STATUS, 32'h1, "status");
    complete_run();
  end
endmodule
`default_nettype wire
